// ---- adcgs_pkg.sv ----
package adcgs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and group indices
  localparam int unsigned CHAN_N = 16;
  localparam int unsigned RES_W  = 10;
  localparam logic [1:0]  GRP_EV = 2'h0;
  localparam logic [1:0]  GRP_G1 = 2'h1;
  localparam logic [1:0]  GRP_G2 = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // field positions (kept for software views of the loose bits)
  localparam int unsigned PRESCALER_LSB   = 0;
  localparam int unsigned SAMPLE_WIN_LSB  = 0;
  localparam int unsigned SELF_CHECK_BIT  = 9;
  localparam int unsigned CAL_EN_BIT      = 13;
  localparam int unsigned GROUP_TWO_CONTINUOUS_BIT_BIT     = 2;
  localparam int unsigned BUSY_LSB        = 11;
  localparam int unsigned BYTE_SHIFT_BITS = 2;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned PU_STAB_NS     = 1000;
  localparam int unsigned PU_STAB_CYC    = (PU_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  PU_STAB_CNT    = 8'(PU_STAB_CYC);
  localparam logic [8:0]  SAMPLE_BASE    = 9'h002;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [2:0]  RST_TRIG_SYNC = 3'h0;
  localparam logic [2:0]  RST_DIV       = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer states
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_SEARCH = 5'h02,
    ST_CHECK  = 5'h04,
    ST_SAMPLE = 5'h08,
    ST_CONV   = 5'h10
  } adcgs_state_t;

endpackage

// ---- adcgs_chan_finder.sv ----
`timescale 1ns/10ps
// finds the lowest selected channel at or above a start position
module adcgs_chan_finder (
  input  wire logic [15:0] sel,
  input  wire logic [4:0]  start,
  output logic             found,
  output logic [3:0]       chan
);

  always_comb begin
    found = 1'b0;
    chan  = 4'h0;
    for (int i = adcgs_pkg::CHAN_N - 1; i >= 0; i--) begin
      if (sel[i] && (5'(i) >= start)) begin
        found = 1'b1;
        chan  = 4'(i);
      end
    end
  end

endmodule // adcgs_chan_finder

// ---- adcgs_sequencer.sv ----
`timescale 1ns/10ps

// Notes on behaviour
// - with byte output on, a result read from a FIFO is shifted right two places
// - event, group one and group two FIFOs each have their own byte shift enable
// - byte shift only in buffered mode; ignored in result register mode
// - timing from prescaler and sample window, or per-group eight-bit sample times
// - self check enable inserts a failure detection step before each conversion
// - calibration enable disconnects the input multiplexer, only reference reaches core
// - power down stops the converter clock; a stabilization wait follows release
// - each group chooses single or continuous conversion independently, except group two while both other groups are continuous
// - all three continuous forces group two single and clears its mode readback
// - single mode converts each selected channel once in order, then stops
// - one busy flag per group, set from request acceptance to last conversion
// - continuous scans low to high; after highest, pending requests go first
// - new requests beat continuous groups; two continuous groups alternate
// - busy stays set while continuous conversion remains active
// - writing zero to a group's channel select stops it immediately
// - clearing a mode bit stops the group after the current conversion
// - one converter clock per skipped channel; next channel found during conversion
// - event group starts on matching trigger edge; select write only configures
// - event select rewrite: finish channel, load new set, continue from the next channel of the old set
// - writing group one or two select configures and starts the group
// - group one or two rewrite: finish channel, new request, rescan from lowest
module adcgs_sequencer (
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic                         external_trigger_pin,
  input  wire logic                         trigger_polarity,
  input  wire logic [15:0]                  event_channel_select,
  input  wire logic [15:0]                  group_one_channel_select,
  input  wire logic [15:0]                  group_two_channel_select,
  input  wire logic                         event_select_wr,
  input  wire logic                         group_one_select_wr,
  input  wire logic                         group_two_select_wr,
  input  wire logic                         event_group_continuous_bit,
  input  wire logic                         group_one_continuous_bit,
  input  wire logic                         group_two_continuous_bit,
  input  wire logic [2:0]                   clock_prescaler_field,
  input  wire logic [1:0]                   sample_window_length,
  input  wire logic                         use_group_sample_time,
  input  wire logic [7:0]                   event_group_sample_time,
  input  wire logic [7:0]                   group_one_sample_time,
  input  wire logic [7:0]                   group_two_sample_time,
  input  wire logic                         self_check_enable,
  input  wire logic                         calibration_enable,
  input  wire logic                         power_down,
  input  wire logic                         buffered_mode,
  input  wire logic                         event_group_byte_shift_en,
  input  wire logic                         group_one_byte_shift_en,
  input  wire logic                         group_two_byte_shift_en,
  input  wire logic                         core_done,
  input  wire logic [adcgs_pkg::RES_W-1:0]  core_result,
  input  wire logic                         fifo_rd_valid,
  input  wire logic [1:0]                   fifo_rd_group,
  input  wire logic [adcgs_pkg::RES_W-1:0]  fifo_rd_raw,
  output logic                              converter_clock_en,
  output logic                              converter_ready,
  output logic                              core_start,
  output logic [3:0]                        core_channel,
  output logic [1:0]                        core_group,
  output logic                              core_mux_enable,
  output logic                              core_self_check,
  output logic                              result_valid,
  output logic [1:0]                        result_group,
  output logic [3:0]                        result_channel,
  output logic [adcgs_pkg::RES_W-1:0]       result_data,
  output logic                              read_valid,
  output logic [adcgs_pkg::RES_W-1:0]       read_data,
  output logic [2:0]                        group_busy,
  output logic                              group_two_continuous_readback
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2:0]                  trig_sync;
    logic                        trig_lvl;
    logic                        trig_pulse;
    logic [2:0]                  div_cnt;
    logic                        converter_internal_clock_en;
    logic [7:0]                  stab_cnt;
    logic                        ready;
    adcgs_pkg::adcgs_state_t     state;
    logic [1:0]                  grp;
    logic [1:0]                  last_grp;
    logic [3:0]                  pos;
    logic [15:0]                 sel;
    logic [8:0]                  samp_cnt;
    logic                        run_cont;
    logic                        ev_reload;
    logic [2:0]                  req;
    logic [2:0]                  standing;
    logic [2:0]                  busy;
    logic                        g2_rb;
    logic                        core_start;
    logic                        mux_en;
    logic                        self_chk;
    logic                        res_valid;
    logic [1:0]                  res_grp;
    logic [3:0]                  res_chan;
    logic [adcgs_pkg::RES_W-1:0] res_data;
    logic                        rd_valid;
    logic [adcgs_pkg::RES_W-1:0] rd_data;
  } adcgs_regs_t;

  adcgs_regs_t s_ff;
  adcgs_regs_t nxt_s;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [1:0] pick(input logic [2:0] v);
    if (v[0])      pick = adcgs_pkg::GRP_EV;
    else if (v[1]) pick = adcgs_pkg::GRP_G1;
    else           pick = adcgs_pkg::GRP_G2;
  endfunction

  function automatic logic [2:0] onehot(input logic [1:0] g);
    onehot = 3'h1 << g;
  endfunction

  function automatic logic [8:0] sample_len(input logic use_grp, input logic [7:0] gt,
                                            input logic [1:0] win);
    if (use_grp) sample_len = {1'b0, gt} + 9'h001;
    else         sample_len = adcgs_pkg::SAMPLE_BASE << win;
  endfunction

  logic [15:0] sel_of   [3];
  logic [7:0]  stime_of [3];
  logic [2:0]  shift_en;
  logic [2:0]  cont;
  logic [2:0]  wr;
  logic [2:0]  nz;
  logic [2:0]  stop;
  logic        tick;
  logic        abort;
  logic        nf_found;
  logic [3:0]  nf_chan;

  assign sel_of[0]   = event_channel_select;
  assign sel_of[1]   = group_one_channel_select;
  assign sel_of[2]   = group_two_channel_select;
  assign stime_of[0] = event_group_sample_time;
  assign stime_of[1] = group_one_sample_time;
  assign stime_of[2] = group_two_sample_time;
  assign shift_en    = {group_two_byte_shift_en, group_one_byte_shift_en, event_group_byte_shift_en};
  // group two cannot run continuous alongside the other two
  assign cont  = {group_two_continuous_bit & ~(event_group_continuous_bit & group_one_continuous_bit),
                  group_one_continuous_bit, event_group_continuous_bit};
  assign wr    = {group_two_select_wr, group_one_select_wr, event_select_wr};
  assign nz    = {|group_two_channel_select, |group_one_channel_select, |event_channel_select};
  assign stop  = wr & ~nz;
  assign tick  = s_ff.converter_internal_clock_en & s_ff.ready & ~calibration_enable;
  assign abort = (s_ff.state != adcgs_pkg::ST_IDLE) && stop[s_ff.grp];

  // next selected channel is found while the current one converts
  adcgs_chan_finder u_next (
    .sel   (s_ff.sel),
    .start ({1'b0, s_ff.pos} + 5'h01),
    .found (nf_found),
    .chan  (nf_chan)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [1:0] g;
    logic [2:0] cand;
    logic       fin;
    g     = 2'h0;
    cand  = 3'h0;
    fin   = 1'b0;
    nxt_s = s_ff;
    nxt_s.core_start = 1'b0;
    nxt_s.res_valid  = 1'b0;
    nxt_s.rd_valid   = 1'b0;
    nxt_s.trig_pulse = 1'b0;

    // trigger pin: three flops, level taken once the last two agree
    nxt_s.trig_sync = {s_ff.trig_sync[1:0], external_trigger_pin};
    if ((s_ff.trig_sync[1] == s_ff.trig_sync[2]) && (s_ff.trig_sync[2] != s_ff.trig_lvl)) begin
      nxt_s.trig_lvl   = s_ff.trig_sync[2];
      nxt_s.trig_pulse = (s_ff.trig_sync[2] == trigger_polarity);
    end

    // converter clock: stopped in power down, then a stabilization wait
    if (power_down) begin
      nxt_s.div_cnt  = adcgs_pkg::RST_DIV;
      nxt_s.converter_internal_clock_en  = 1'b0;
      nxt_s.stab_cnt = adcgs_pkg::PU_STAB_CNT;
      nxt_s.ready    = 1'b0;
    end else begin
      nxt_s.converter_internal_clock_en = (s_ff.div_cnt == clock_prescaler_field);
      nxt_s.div_cnt = nxt_s.converter_internal_clock_en ? adcgs_pkg::RST_DIV : s_ff.div_cnt + 3'h1;
      if (s_ff.stab_cnt != 8'h00) begin
        nxt_s.stab_cnt = s_ff.stab_cnt - 8'h01;
      end
      nxt_s.ready = (s_ff.stab_cnt == 8'h00);
    end

    nxt_s.g2_rb    = cont[2];
    nxt_s.mux_en   = ~calibration_enable;

    // requests: group one/two start on a non-zero select write, event on its edge
    nxt_s.req = s_ff.req | {wr[2] & nz[2], wr[1] & nz[1], s_ff.trig_pulse};
    if (wr[0] && nz[0] && (s_ff.state != adcgs_pkg::ST_IDLE) && (s_ff.grp == adcgs_pkg::GRP_EV)) begin
      nxt_s.ev_reload = 1'b1;
    end

    case (s_ff.state)
      adcgs_pkg::ST_IDLE: begin
        // calibration freezes sequencing; no start before the clock is stable
        if (s_ff.ready && !calibration_enable && ((s_ff.req | s_ff.standing) != 3'h0)) begin
          if (s_ff.req != 3'h0) begin
            g = pick(s_ff.req);
          end else begin
            // a standing group yields to the other standing one
            cand = s_ff.standing & ~onehot(s_ff.last_grp);
            g    = pick((cand != 3'h0) ? cand : s_ff.standing);
          end
          nxt_s.grp       = g;
          nxt_s.last_grp  = g;
          nxt_s.sel       = sel_of[g];
          nxt_s.pos       = 4'h0;
          nxt_s.run_cont  = cont[g];
          nxt_s.ev_reload = 1'b0;
          nxt_s.req       = (nxt_s.req & ~onehot(g)) | {2'h0, s_ff.trig_pulse}; // retrigger in same cycle wins
          nxt_s.standing  = s_ff.standing & ~onehot(g);
          nxt_s.state     = adcgs_pkg::ST_SEARCH;
        end
      end
      adcgs_pkg::ST_SEARCH: begin
        if (tick) begin
          if (s_ff.sel[s_ff.pos]) begin
            nxt_s.samp_cnt = sample_len(use_group_sample_time, stime_of[s_ff.grp], sample_window_length);
            nxt_s.state    = self_check_enable ? adcgs_pkg::ST_CHECK : adcgs_pkg::ST_SAMPLE;
          end else if (s_ff.pos == 4'hf) begin
            fin = 1'b1;
          end else begin
            nxt_s.pos = s_ff.pos + 4'h1;
          end
        end
      end
      adcgs_pkg::ST_CHECK: begin
        if (tick) begin
          if (s_ff.samp_cnt <= 9'h001) begin
            nxt_s.samp_cnt = sample_len(use_group_sample_time, stime_of[s_ff.grp], sample_window_length);
            nxt_s.state    = adcgs_pkg::ST_SAMPLE;
          end else begin
            nxt_s.samp_cnt = s_ff.samp_cnt - 9'h001;
          end
        end
      end
      adcgs_pkg::ST_SAMPLE: begin
        if (tick) begin
          if (s_ff.samp_cnt <= 9'h001) begin
            nxt_s.core_start = 1'b1;
            nxt_s.state      = adcgs_pkg::ST_CONV;
          end else begin
            nxt_s.samp_cnt = s_ff.samp_cnt - 9'h001;
          end
        end
      end
      adcgs_pkg::ST_CONV: begin
        if (core_done) begin
          nxt_s.res_valid = 1'b1;
          nxt_s.res_grp   = s_ff.grp;
          nxt_s.res_chan  = s_ff.pos;
          nxt_s.res_data  = core_result;
          if (s_ff.req[s_ff.grp]) begin
            // rewrite or retrigger: back through arbitration, rescan from channel 0
            nxt_s.state = adcgs_pkg::ST_IDLE;
          end else if (s_ff.run_cont && !cont[s_ff.grp]) begin
            nxt_s.state = adcgs_pkg::ST_IDLE;
          end else if (s_ff.ev_reload) begin
            // positions already passed in the old set stay skipped this cycle
            nxt_s.sel       = event_channel_select;
            nxt_s.ev_reload = 1'b0;
            if (nf_found) begin
              nxt_s.pos   = nf_chan;
              nxt_s.state = adcgs_pkg::ST_SEARCH;
            end else begin
              fin = 1'b1;
            end
          end else if (nf_found) begin
            nxt_s.pos      = nf_chan;
            nxt_s.samp_cnt = sample_len(use_group_sample_time, stime_of[s_ff.grp], sample_window_length);
            nxt_s.state    = self_check_enable ? adcgs_pkg::ST_CHECK : adcgs_pkg::ST_SAMPLE;
          end else begin
            fin = 1'b1;
          end
        end
      end
      default: begin
        nxt_s.state = adcgs_pkg::ST_IDLE;
      end
    endcase

    // end of a scan: a continuous group becomes a standing request
    if (fin) begin
      nxt_s.state = adcgs_pkg::ST_IDLE;
      if (s_ff.run_cont && cont[s_ff.grp] && (sel_of[s_ff.grp] != 16'h0000)) begin
        nxt_s.standing = nxt_s.standing | onehot(s_ff.grp);
      end
    end

    // zero select write: stop at once, a late core answer is then ignored
    nxt_s.req      = nxt_s.req & ~stop;
    nxt_s.standing = nxt_s.standing & ~stop;
    if (abort || stop[nxt_s.grp]) begin
      nxt_s.state      = adcgs_pkg::ST_IDLE;
      nxt_s.core_start = 1'b0;
    end

    nxt_s.busy = nxt_s.req | nxt_s.standing |
                 ((nxt_s.state != adcgs_pkg::ST_IDLE) ? onehot(nxt_s.grp) : 3'h0);
    nxt_s.self_chk = (nxt_s.state == adcgs_pkg::ST_CHECK);

    // byte mode read: drop the two low result bits, buffered mode only
    if (fifo_rd_valid) begin
      nxt_s.rd_valid = 1'b1;
      nxt_s.rd_data  = (buffered_mode && shift_en[fifo_rd_group]) ?
                       (fifo_rd_raw >> adcgs_pkg::BYTE_SHIFT_BITS) : fifo_rd_raw;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_ff           <= '0;
      s_ff.trig_sync <= adcgs_pkg::RST_TRIG_SYNC;
      s_ff.stab_cnt  <= adcgs_pkg::PU_STAB_CNT;
      s_ff.state     <= adcgs_pkg::ST_IDLE;
      s_ff.mux_en    <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign converter_clock_en            = s_ff.converter_internal_clock_en;
  assign converter_ready               = s_ff.ready;
  assign core_start                    = s_ff.core_start;
  assign core_channel                  = s_ff.pos;
  assign core_group                    = s_ff.grp;
  assign core_mux_enable               = s_ff.mux_en;
  assign core_self_check               = s_ff.self_chk;
  assign result_valid                  = s_ff.res_valid;
  assign result_group                  = s_ff.res_grp;
  assign result_channel                = s_ff.res_chan;
  assign result_data                   = s_ff.res_data;
  assign read_valid                    = s_ff.rd_valid;
  assign read_data                     = s_ff.rd_data;
  assign group_busy                    = s_ff.busy;
  assign group_two_continuous_readback = s_ff.g2_rb;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_byte_shift_read: assert property (fifo_rd_valid && buffered_mode && shift_en[fifo_rd_group] |=>
    read_data == ($past(fifo_rd_raw) >> 2)) else $error("byte shift not applied");
  chk_no_shift_unbuf: assert property (fifo_rd_valid && !buffered_mode |=>
    read_data == $past(fifo_rd_raw)) else $error("shift applied outside buffered mode");
  chk_g2_forced_single: assert property (event_group_continuous_bit && group_one_continuous_bit |=>
    !group_two_continuous_readback) else $error("group two readback not cleared");
  chk_mux_off_cal: assert property (calibration_enable |=> !core_mux_enable)
    else $error("mux enabled during calibration");
  chk_pd_clock_stop: assert property (power_down |=> !converter_clock_en && !converter_ready)
    else $error("converter clock runs in power down");
  chk_zero_sel_stop: assert property (group_one_select_wr && !(|group_one_channel_select) |=>
    !group_busy[1]) else $error("group one not stopped by zero select");
  chk_g1_write_start: assert property (group_one_select_wr && (|group_one_channel_select) |=>
    group_busy[1]) else $error("group one write did not start");
  chk_trig_starts_ev: assert property (s_ff.trig_pulse |=> group_busy[0])
    else $error("trigger edge did not start event group");
  chk_skip_one_tick: assert property (s_ff.state == adcgs_pkg::ST_SEARCH && tick && !s_ff.sel[s_ff.pos]
    && s_ff.pos != 4'hf && !abort |=> s_ff.pos == $past(s_ff.pos) + 4'h1) else $error("skip not one tick");
  chk_start_in_conv: assert property (core_start |-> s_ff.state == adcgs_pkg::ST_CONV && !calibration_enable
    ) else $error("core start outside conversion");

  cov_g2_result: cover property (result_valid && result_group == adcgs_pkg::GRP_G2);
  cov_ev_reload: cover property (s_ff.ev_reload && core_done && s_ff.state == adcgs_pkg::ST_CONV);
  cov_self_check: cover property (core_self_check ##[1:50] core_start);
  cov_standing_swap: cover property (s_ff.standing == 3'h3 && s_ff.state == adcgs_pkg::ST_IDLE);

endmodule // adcgs_sequencer

// ---- adcgs_core_model.sv ----
`timescale 1ns/10ps
// converter core stand-in: fixed latency; between results the result bus inverts itself every cycle
module adcgs_core_model #(
  parameter int LAT = 5
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic                        core_start,
  input  wire logic [3:0]                  core_channel,
  output logic                             core_done,
  output logic [adcgs_pkg::RES_W-1:0]      core_result
);
  int cnt;
  always_ff @(posedge clk_sys) begin
    core_done <= 1'b0;
    core_result <= ~core_result;
    if (rst) begin
      cnt <= 0;
      core_result <= 10'h000;
    end else if (core_start) begin
      cnt <= LAT;
    end else if (cnt == 1) begin
      cnt <= 0;
      core_done <= 1'b1;
      core_result <= {core_channel, 6'h15};
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule // adcgs_core_model

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
  logic clk_sys, rst, external_trigger_pin, trigger_polarity, event_select_wr, group_one_select_wr;
  logic group_two_select_wr, event_group_continuous_bit, group_one_continuous_bit, group_two_continuous_bit;
  logic use_group_sample_time, self_check_enable, calibration_enable, power_down, buffered_mode;
  logic event_group_byte_shift_en, group_one_byte_shift_en, group_two_byte_shift_en, core_done, fifo_rd_valid;
  logic converter_clock_en, converter_ready, core_start, core_mux_enable, core_self_check;
  logic result_valid, read_valid, group_two_continuous_readback;
  logic [15:0] event_channel_select, group_one_channel_select, group_two_channel_select;
  logic [7:0]  event_group_sample_time, group_one_sample_time, group_two_sample_time;
  logic [3:0]  core_channel, result_channel;
  logic [2:0]  clock_prescaler_field, group_busy;
  logic [1:0]  sample_window_length, fifo_rd_group, core_group, result_group;
  logic [adcgs_pkg::RES_W-1:0] core_result, fifo_rd_raw, result_data, read_data;
  int error_cnt, checks_done, cyc;

  adcgs_sequencer  adcgs_sequencer_inst (.*);
  adcgs_core_model adcgs_core_model_inst (.*);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // bounded wait on one busy bit
  task automatic wait_busy(input int i, input logic v);
    for (int n = 0; n < 60 && group_busy[i] !== v; n++) @(negedge clk_sys);
  endtask
  task automatic expect_result(input logic [3:0] ch, input logic [1:0] grp);
    for (int n = 0; n < 200 && result_valid !== 1'b1; n++) @(negedge clk_sys);
    check({9'h0, result_valid, result_group, result_channel}, {9'h0, 1'b1, grp, ch});
    check({6'h0, result_data}, {6'h0, ch, 6'h15});
    @(negedge clk_sys);
  endtask
  task automatic sel_write(input int g, input logic [15:0] v);
    if (g == 0) event_channel_select = v;
    if (g == 1) group_one_channel_select = v;
    if (g == 2) group_two_channel_select = v;
    {group_two_select_wr, group_one_select_wr, event_select_wr} = 3'h1 << g;
    @(negedge clk_sys);
    {group_two_select_wr, group_one_select_wr, event_select_wr} = 3'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_fifo_shift;
    logic [9:0] raw;
    fifo_rd_valid = 1'b1;
    for (int b = 0; b < 2; b++) begin
      for (int g = 0; g < 3; g++) begin
        buffered_mode = b[0];
        {group_two_byte_shift_en, group_one_byte_shift_en, event_group_byte_shift_en} = 3'h1 << g;
        for (int r = 0; r < 3; r++) begin
          raw = 10'h3ff - 10'(r);
          fifo_rd_group = 2'(r);
          fifo_rd_raw = raw;
          @(negedge clk_sys);
          check({5'h0, read_valid, read_data}, {6'h01, (b == 1 && r == g) ? raw >> 2 : raw});
        end
      end
    end
    fifo_rd_valid = 1'b0;
    $display("fifo shift test done");
  endtask
  task automatic test_g1_single;
    sel_write(1, 16'h0003);
    check({15'h0, group_busy[1]}, 16'h1);
    expect_result(4'h0, adcgs_pkg::GRP_G1);
    expect_result(4'h1, adcgs_pkg::GRP_G1);
    @(negedge clk_sys);
    check({15'h0, group_busy[1]}, 16'h0);
    $display("single scan test done");
  endtask
  task automatic test_event;
    trigger_polarity = 1'b1;
    sel_write(0, 16'h0001);
    repeat (20) @(negedge clk_sys);
    check({15'h0, group_busy[0]}, 16'h0);
    external_trigger_pin = 1'b1;
    wait_busy(0, 1'b1);
    check({15'h0, group_busy[0]}, 16'h1);
    expect_result(4'h0, adcgs_pkg::GRP_EV);
    external_trigger_pin = 1'b0;
    wait_busy(0, 1'b0);
    $display("event trigger test done");
  endtask
  task automatic test_cont_stop;
    group_one_continuous_bit = 1'b1;
    sel_write(1, 16'h0005);
    expect_result(4'h0, adcgs_pkg::GRP_G1);
    expect_result(4'h2, adcgs_pkg::GRP_G1);
    expect_result(4'h0, adcgs_pkg::GRP_G1);
    check({15'h0, group_busy[1]}, 16'h1);
    sel_write(1, 16'h0000);
    check({15'h0, group_busy[1]}, 16'h0);
    sel_write(1, 16'h0005);
    expect_result(4'h0, adcgs_pkg::GRP_G1);
    group_one_continuous_bit = 1'b0;
    expect_result(4'h2, adcgs_pkg::GRP_G1);
    check({15'h0, group_busy[1]}, 16'h0);
    $display("continuous stop test done");
  endtask
  task automatic test_self_check;
    int n;
    self_check_enable = 1'b1;
    use_group_sample_time = 1'b1;
    group_two_sample_time = 8'h03;
    sel_write(2, 16'h0010);
    for (n = 0; n < 60 && core_self_check !== 1'b1; n++) @(negedge clk_sys);
    check({10'h0, core_group, core_channel}, {10'h0, adcgs_pkg::GRP_G2, 4'h4});
    for (n = 0; n < 60 && core_self_check === 1'b1; n++) @(negedge clk_sys);
    check(16'(n), 16'h0004);
    expect_result(4'h4, adcgs_pkg::GRP_G2);
    {self_check_enable, use_group_sample_time} = 2'h0;
    $display("self check test done");
  endtask
  task automatic test_modes;
    for (int m = 0; m < 8; m++) begin
      {group_two_continuous_bit, group_one_continuous_bit, event_group_continuous_bit} = 3'(m);
      repeat (2) @(negedge clk_sys);
      check({15'h0, group_two_continuous_readback}, {15'h0, m[2] && m != 7});
    end
    {group_two_continuous_bit, group_one_continuous_bit, event_group_continuous_bit} = 3'h0;
    calibration_enable = 1'b1;
    repeat (2) @(negedge clk_sys);
    check({15'h0, core_mux_enable}, 16'h0);
    calibration_enable = 1'b0;
    power_down = 1'b1;
    repeat (2) @(negedge clk_sys);
    check({14'h0, converter_ready, converter_clock_en}, 16'h0);
    power_down = 1'b0;
    repeat (8) @(negedge clk_sys);
    check({14'h0, converter_ready, core_mux_enable}, 16'h1);
    repeat (5) @(negedge clk_sys);
    check({15'h0, converter_ready}, 16'h1);
    $display("mode bits test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {external_trigger_pin, trigger_polarity, event_select_wr, group_one_select_wr, group_two_select_wr} = '0;
    {event_group_continuous_bit, group_one_continuous_bit, group_two_continuous_bit, use_group_sample_time} = '0;
    {self_check_enable, calibration_enable, power_down, buffered_mode, fifo_rd_valid} = '0;
    {event_group_byte_shift_en, group_one_byte_shift_en, group_two_byte_shift_en} = '0;
    {event_channel_select, group_one_channel_select, group_two_channel_select, fifo_rd_group, fifo_rd_raw} = '0;
    {clock_prescaler_field, sample_window_length} = '0;
    {event_group_sample_time, group_one_sample_time, group_two_sample_time} = '0;
    rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    repeat (13) @(negedge clk_sys);
    check({15'h0, converter_ready}, 16'h1);
    test_fifo_shift();
    test_g1_single();
    test_event();
    test_cont_stop();
    test_self_check();
    test_modes();
    wrap_up();
  end
endmodule // testbench
